// File: tsa_bus_master.sv
module tsa_bus_master (
  // Clock
  input  wire logic       mclk,
  // Byte layer towards the device
  output logic            busReset,
  output logic            cmdValid,
  output logic [7:0]      cmdByte,
  output logic            wrValid,
  output logic [7:0]      wrByte,
  output logic            rdSlot,
  input  wire logic       rdValid_q,
  input  wire logic       rdBit_q,
  // Alarm search
  output logic            searchReq,
  input  wire logic       searchJoin_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {busReset, cmdValid, wrValid, rdSlot, searchReq} = 5'h00;
    cmdByte = 8'h00;
    wrByte  = 8'h00;
  end

  // One-cycle strobe: 0 bus reset, 1 command, 2 write, 3 read slot, 4 search
  task automatic pulse(input int k);
    @(posedge mclk);
    case (k)
      0:       busReset  <= 1'b1;
      1:       cmdValid  <= 1'b1;
      2:       wrValid   <= 1'b1;
      3:       rdSlot    <= 1'b1;
      default: searchReq <= 1'b1;
    endcase
    @(posedge mclk);
    case (k)
      0:       busReset  <= 1'b0;
      1:       cmdValid  <= 1'b0;
      2:       wrValid   <= 1'b0;
      3:       rdSlot    <= 1'b0;
      default: searchReq <= 1'b0;
    endcase
  endtask : pulse

  task automatic bus_init();
    pulse(0);
  endtask : bus_init

  // Released byte lines carry the inverse, never the old value
  task automatic cmd(input logic [7:0] b);
    cmdByte <= b;
    pulse(1);
    cmdByte <= ~b;
  endtask : cmd

  task automatic wr(input logic [7:0] b);
    wrByte <= b;
    pulse(2);
    wrByte <= ~b;
  endtask : wr

  task automatic rd(input int n, output logic [71:0] v);
    v = '1;
    for (int i = 0; i < n; i++) begin
      pulse(3);
      @(negedge mclk);
      v[i] = rdValid_q ? rdBit_q : 1'bx;
    end
  endtask : rd

  task automatic search(output logic j);
    pulse(4);
    @(negedge mclk);
    j = searchJoin_q;
  endtask : search

  // Quiet bus while the copy runs
  task automatic quiet(input int n);
    repeat (n) @(posedge mclk);
  endtask : quiet
endmodule : tsa_bus_master

// File: tsa_nv_store.sv
module tsa_nv_store #(
  parameter int          WRITE_CYCLES = tsa_pkg::COPY_CYCLES,
  parameter int          READ_CYCLES  = tsa_pkg::RELOAD_CYCLES,
  parameter logic [15:0] INIT_VALUE   = {tsa_pkg::UPPER_DEFAULT, tsa_pkg::LOWER_DEFAULT}
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 srst,
  // Requests
  input  wire logic                 wrEn,
  input  wire tsa_pkg::tsa_limits_t wrData,
  input  wire logic                 rdEn,
  // Results
  output tsa_pkg::tsa_limits_t      rdData_q,
  output logic                      rdDone_q,
  output logic                      busy_q
);

  tsa_pkg::tsa_limits_t cells_q;
  tsa_pkg::tsa_limits_t pend_q;
  logic [31:0]          cnt_q;
  logic                 writing_q;

  ////////////////////////////////////////////////////////////////////////
  // Timed write or read; requests while busy are dropped
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q    <= 1'b0;
      writing_q <= 1'b0;
      cnt_q     <= '0;
      pend_q    <= '0;
      rdDone_q  <= 1'b0;
    end else begin
      rdDone_q <= 1'b0;
      if (!busy_q && (wrEn || rdEn)) begin
        busy_q    <= 1'b1;
        writing_q <= wrEn;
        pend_q    <= wrData;
        cnt_q     <= 32'(wrEn ? WRITE_CYCLES - 1 : READ_CYCLES - 1);
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          busy_q   <= 1'b0;
          rdDone_q <= !writing_q;
        end else begin
          cnt_q <= cnt_q - 32'd1;
        end
      end
    end
  end

  // Storage cells take their factory content at power-on only
  always_ff @(posedge mclk) begin
    if (srst) begin
      cells_q <= INIT_VALUE;
    end else if (busy_q && writing_q && cnt_q == '0) begin
      cells_q <= pend_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData_q <= '0;
    end else if (busy_q && !writing_q && cnt_q == '0) begin
      rdData_q <= cells_q;
    end
  end

endmodule : tsa_nv_store

// File: tsa_pkg.sv
package tsa_pkg;

  // Scratchpad byte indices
  localparam logic [3:0] IDX_TEMP_LO   = 4'h0;
  localparam logic [3:0] IDX_TEMP_HI   = 4'h1;
  localparam logic [3:0] IDX_UPPER_LIM = 4'h2;
  localparam logic [3:0] IDX_LOWER_LIM = 4'h3;
  localparam logic [3:0] IDX_RSVD_A    = 4'h4;
  localparam logic [3:0] IDX_RSVD_B    = 4'h5;
  localparam logic [3:0] IDX_REMAIN    = 4'h6;
  localparam logic [3:0] IDX_PER_DEG   = 4'h7;
  localparam logic [3:0] IDX_CRC       = 4'h8;
  localparam int         PAD_BYTES     = 9;
  localparam int         PAD_BITS      = PAD_BYTES * 8;
  localparam int         CRC_DATA_BITS = 64;
  localparam int         ROM_DATA_BITS = 56;

  // Function commands
  localparam logic [7:0] CMD_CONVERT   = 8'h44;
  localparam logic [7:0] CMD_WRITE_PAD = 8'h4E;
  localparam logic [7:0] CMD_READ_PAD  = 8'hBE;
  localparam logic [7:0] CMD_COPY_PAD  = 8'h48;
  localparam logic [7:0] CMD_RELOAD    = 8'hB8;
  localparam logic [7:0] CMD_READ_PWR  = 8'hB4;

  // Fixed values
  localparam logic [15:0] TEMP_RESET     = 16'h00AA;
  localparam logic [7:0]  RSVD_VALUE     = 8'hFF;
  localparam logic [7:0]  PER_DEG_VALUE  = 8'h10;
  localparam logic [7:0]  REMAIN_RESET   = 8'h0C;
  localparam logic [7:0]  CRC_POLY_REFL  = 8'h8C;
  localparam logic [7:0]  UPPER_DEFAULT  = 8'h4B;
  localparam logic [7:0]  LOWER_DEFAULT  = 8'h46;

  // Timing
  localparam int CLK_MHZ         = 40;
  localparam int COPY_TIME_US    = 10000;
  localparam int COPY_CYCLES     = COPY_TIME_US * CLK_MHZ;
  localparam int RELOAD_CYCLES   = 8;

  // Read-slot answer source
  typedef enum logic [4:0] {
    RD_IDLE   = 5'b00001,
    RD_PAD    = 5'b00010,
    RD_POWER  = 5'b00100,
    RD_CONV   = 5'b01000,
    RD_RELOAD = 5'b10000
  } tsa_rdmode_t;

  // Conversion result from the analogue front end
  typedef struct packed {
    logic [15:0] temp;
    logic [7:0]  remain;
  } tsa_conv_t;

  // Alarm limit pair as kept in storage
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } tsa_limits_t;

endpackage : tsa_pkg

// File: tsa_thermo_pad.sv
// Operation
// - Compare temperature bits 8..1 only against each limit byte.
// - Alarm when temp <= lower or temp > upper, signed compare.
// - Alarm flag re-evaluated after every conversion, cleared when condition gone.
// - Alarm search participation only while the alarm flag is set.
// - Each limit is a signed two's complement byte.
// - Limits live at pad bytes 2 and 3, backed by nonvolatile storage.
// - Power-supply read slot: low if parasite, high if external.
// - Identity code: family byte, 48-bit serial, CRC over 56 bits.
// - Pad bytes 0 and 1 give temperature and ignore writes.
// - Pad bytes 4 and 5 read all ones, not writable.
// - Pad bytes 6 and 7 hold remaining count and counts per degree.
// - Pad byte 8 is a read-only CRC over bytes 0 to 7.
// - Write-pad command loads byte 2 then byte 3, LSB first.
// - Read-pad shifts out from LSB of byte 0.
// - Copy command writes both limit bytes to nonvolatile storage.
// - Stored limits load into bytes 2 and 3 at power-up.
// - Reload command restores limits; read slots give 0 busy, 1 done.
// - External power: read slots after convert give 0 busy, 1 done.
// - Temperature is 16-bit sign-extended, bit 0 is half degree.
// - All bytes travel least significant bit first.
// - Both CRCs use x^8+x^5+x^4+1 from a zero start.
module tsa_thermo_pad #(
  parameter int          COPY_CYCLES   = tsa_pkg::COPY_CYCLES,
  parameter int          RELOAD_CYCLES = tsa_pkg::RELOAD_CYCLES,
  parameter logic [7:0]  FAMILY_CODE   = 8'h5A,          // Arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0123456789AB // Arbitrary value
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                srst,
  // Byte layer from the slot engine
  input  wire logic                busReset,
  input  wire logic                cmdValid,
  input  wire logic [7:0]          cmdByte,
  input  wire logic                wrValid,
  input  wire logic [7:0]          wrByte,
  input  wire logic                rdSlot,
  output logic                     rdValid_q,
  output logic                     rdBit_q,
  // Alarm search from the ROM layer
  input  wire logic                searchReq,
  output logic                     searchJoin_q,
  output logic                     alarmFlag_q,
  // Converter
  output logic                     convStart_q,
  input  wire logic                convDone,
  input  wire tsa_pkg::tsa_conv_t  convResult,
  // Supply sense pin, high when parasite powered
  input  wire logic                parasitePin,
  // Identity code
  output logic [63:0]              romCode_q
);

  ////////////////////////////////////////////////////////////////////////
  // CRC, reflected form of x^8+x^5+x^4+1, zero start, LSB first
  function automatic logic [7:0] crcCalc(input logic [63:0] data, input int nBits);
    logic [7:0] c;
    logic       fb;
    c  = '0;
    fb = 1'b0;
    for (int i = 0; i < 64; i++) begin
      if (i < nBits) begin
        fb = c[0] ^ data[i];
        c  = {1'b0, c[7:1]};
        if (fb) begin
          c = c ^ tsa_pkg::CRC_POLY_REFL;
        end
      end
    end
    return c;
  endfunction : crcCalc

  tsa_pkg::tsa_rdmode_t rdMode_q;
  logic [15:0]          temp_q;
  logic [7:0]           remain_q;
  logic [7:0]           upper_q;
  logic [7:0]           lower_q;
  logic [7:0]           padCrc_q;
  logic [6:0]           bitIdx_q;
  logic                 wrIdx_q;
  logic                 converting_q;
  logic                 bootLoad_q;
  logic                 parSync1_q;
  logic                 parSync2_q;
  logic [63:0]          padBody;
  logic [71:0]          padAll;
  logic                 nvWr;
  logic                 nvRd;
  tsa_pkg::tsa_limits_t nvRdData;
  logic                 nvRdDone;
  logic                 nvBusy;
  logic signed [7:0]    tempCmp;
  logic                 wrEnable_q;

  ////////////////////////////////////////////////////////////////////////
  // Supply sense synchroniser
  always_ff @(posedge mclk) begin
    if (srst) begin
      parSync1_q <= 1'b0;
      parSync2_q <= 1'b0;
    end else begin
      parSync1_q <= parasitePin;
      parSync2_q <= parSync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scratchpad image, byte 0 in the low bits
  always_comb begin
    padBody = {tsa_pkg::PER_DEG_VALUE, remain_q,
               tsa_pkg::RSVD_VALUE, tsa_pkg::RSVD_VALUE,
               lower_q, upper_q,
               temp_q[15:8], temp_q[7:0]};
    padAll  = {padCrc_q, padBody};
  end

  // Recomputed every cycle so it tracks any pad change
  always_ff @(posedge mclk) begin
    if (srst) begin
      padCrc_q <= '0;
    end else begin
      padCrc_q <= crcCalc(padBody, tsa_pkg::CRC_DATA_BITS);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      romCode_q <= '0;
    end else begin
      romCode_q <= {crcCalc({8'h00, SERIAL_NUMBER, FAMILY_CODE},
                            tsa_pkg::ROM_DATA_BITS),
                    SERIAL_NUMBER, FAMILY_CODE};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion result and alarm compare
  always_ff @(posedge mclk) begin
    if (srst) begin
      converting_q <= 1'b0;
      convStart_q  <= 1'b0;
    end else begin
      convStart_q <= cmdValid && cmdByte == tsa_pkg::CMD_CONVERT && !converting_q;
      if (cmdValid && cmdByte == tsa_pkg::CMD_CONVERT) begin
        converting_q <= 1'b1;
      end else if (convDone) begin
        converting_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      temp_q   <= tsa_pkg::TEMP_RESET;
      remain_q <= tsa_pkg::REMAIN_RESET;
    end else if (convDone && converting_q) begin
      temp_q   <= convResult.temp;
      remain_q <= convResult.remain;
    end
  end

  assign tempCmp = convResult.temp[8:1];

  always_ff @(posedge mclk) begin
    if (srst) begin
      alarmFlag_q <= 1'b0;
    end else if (convDone && converting_q) begin
      alarmFlag_q <= (tempCmp <= $signed(lower_q))
                  || (tempCmp > $signed(upper_q));
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      searchJoin_q <= 1'b0;
    end else begin
      searchJoin_q <= searchReq && alarmFlag_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm limits and nonvolatile backing
  assign nvWr = cmdValid && cmdByte == tsa_pkg::CMD_COPY_PAD;
  assign nvRd = bootLoad_q || (cmdValid && cmdByte == tsa_pkg::CMD_RELOAD);

  always_ff @(posedge mclk) begin
    if (srst) begin
      bootLoad_q <= 1'b1;
    end else if (!nvBusy) begin
      bootLoad_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      upper_q <= '0;
      lower_q <= '0;
      wrIdx_q <= 1'b0;
    end else begin
      if (cmdValid) begin
        wrIdx_q <= 1'b0;
      end
      if (nvRdDone) begin
        upper_q <= nvRdData.upper;
        lower_q <= nvRdData.lower;
      end else if (wrValid && rdMode_q == tsa_pkg::RD_IDLE && wrEnable_q) begin
        if (!wrIdx_q) begin
          upper_q <= wrByte;
          wrIdx_q <= 1'b1;
        end else begin
          lower_q <= wrByte;
        end
      end
    end
  end

  // Write-pad window opened by the command, closed after the second byte
  always_ff @(posedge mclk) begin
    if (srst || busReset) begin
      wrEnable_q <= 1'b0;
    end else if (cmdValid) begin
      wrEnable_q <= cmdByte == tsa_pkg::CMD_WRITE_PAD;
    end else if (wrValid && wrIdx_q) begin
      wrEnable_q <= 1'b0;
    end
  end

  tsa_nv_store #(
    .WRITE_CYCLES (COPY_CYCLES),
    .READ_CYCLES  (RELOAD_CYCLES),
    .INIT_VALUE   ({tsa_pkg::UPPER_DEFAULT, tsa_pkg::LOWER_DEFAULT})
  ) uNvStore (
    .mclk     (mclk),
    .srst     (srst),
    .wrEn     (nvWr),
    .wrData   ({upper_q, lower_q}),
    .rdEn     (nvRd),
    .rdData_q (nvRdData),
    .rdDone_q (nvRdDone),
    .busy_q   (nvBusy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read-slot answers
  always_ff @(posedge mclk) begin
    if (srst || busReset) begin
      rdMode_q <= tsa_pkg::RD_IDLE;
    end else if (cmdValid) begin
      case (cmdByte)
        tsa_pkg::CMD_READ_PAD: rdMode_q <= tsa_pkg::RD_PAD;
        tsa_pkg::CMD_READ_PWR: rdMode_q <= tsa_pkg::RD_POWER;
        tsa_pkg::CMD_CONVERT:  rdMode_q <= tsa_pkg::RD_CONV;
        tsa_pkg::CMD_RELOAD:   rdMode_q <= tsa_pkg::RD_RELOAD;
        default:               rdMode_q <= tsa_pkg::RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || busReset || cmdValid) begin
      bitIdx_q <= '0;
    end else if (rdSlot && rdMode_q == tsa_pkg::RD_PAD
                 && bitIdx_q < 7'(tsa_pkg::PAD_BITS)) begin
      bitIdx_q <= bitIdx_q + 7'd1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdValid_q <= 1'b0;
      rdBit_q   <= 1'b1;
    end else begin
      rdValid_q <= rdSlot;
      if (rdSlot) begin
        case (rdMode_q)
          tsa_pkg::RD_PAD:
            rdBit_q <= (bitIdx_q < 7'(tsa_pkg::PAD_BITS)) ? padAll[bitIdx_q] : 1'b1;
          tsa_pkg::RD_POWER:  rdBit_q <= !parSync2_q;
          tsa_pkg::RD_CONV:   rdBit_q <= parSync2_q || !converting_q;
          tsa_pkg::RD_RELOAD: rdBit_q <= !nvBusy;
          default:            rdBit_q <= 1'b1;
        endcase
      end
    end
  end

endmodule : tsa_thermo_pad

// File: tsa_thermo_pad_props.sv
module tsa_thermo_pad_props #(
  parameter logic [7:0]  FAMILY_CODE   = 8'h5A,
  parameter logic [47:0] SERIAL_NUMBER = 48'h0
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // Byte layer
  input wire logic        busReset,
  input wire logic        cmdValid,
  input wire logic [7:0]  cmdByte,
  input wire logic        rdSlot,
  input wire logic        rdValid_q,
  input wire logic        rdBit_q,
  // Alarm, converter, supply, identity
  input wire logic        searchReq,
  input wire logic        searchJoin_q,
  input wire logic        alarmFlag_q,
  input wire logic        convStart_q,
  input wire logic        convDone,
  input wire logic        parasitePin,
  input wire logic [63:0] romCode_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic pwrMode_q;

  // Tracks the supply-query read mode
  always_ff @(posedge mclk) begin
    if (srst || busReset) pwrMode_q <= 1'b0;
    else if (cmdValid) pwrMode_q <= (cmdByte == tsa_pkg::CMD_READ_PWR);
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_rdAnswer; rdSlot |=> rdValid_q; endproperty
  a_rdAnswer: assert property (p_rdAnswer) else $error("read slot not answered");
  property p_rdQuiet; !rdSlot |=> !rdValid_q && $stable(rdBit_q); endproperty
  a_rdQuiet: assert property (p_rdQuiet) else $error("read answer without slot");
  property p_join; searchReq && alarmFlag_q |=> searchJoin_q; endproperty
  a_join: assert property (p_join) else $error("alarmed device silent");
  property p_silent; !(searchReq && alarmFlag_q) |=> !searchJoin_q; endproperty
  a_silent: assert property (p_silent) else $error("search join without alarm");
  property p_flagHold; !convDone |=> $stable(alarmFlag_q); endproperty
  a_flagHold: assert property (p_flagHold) else $error("alarm changed without conversion");
  property p_convStart;
    cmdValid && cmdByte == tsa_pkg::CMD_CONVERT |=> convStart_q ##1 !convStart_q;
  endproperty
  a_convStart: assert property (p_convStart) else $error("conversion not started");
  property p_power;
    pwrMode_q && rdSlot && parasitePin == $past(parasitePin, 3) |=> rdBit_q != $past(parasitePin);
  endproperty
  a_power: assert property (p_power) else $error("supply answer wrong");
  property p_rom; !$past(srst) |-> romCode_q[55:0] == {SERIAL_NUMBER, FAMILY_CODE}; endproperty
  a_rom: assert property (p_rom) else $error("identity code wrong");
  property p_idle; busReset ##2 rdSlot |=> rdBit_q; endproperty
  a_idle: assert property (p_idle) else $error("idle read not one");
endmodule : tsa_thermo_pad_props

bind tsa_thermo_pad tsa_thermo_pad_props #(
  .FAMILY_CODE(FAMILY_CODE), .SERIAL_NUMBER(SERIAL_NUMBER)
) u_tsa_thermo_pad_props (
  .mclk(mclk), .srst(srst), .busReset(busReset), .cmdValid(cmdValid), .cmdByte(cmdByte),
  .rdSlot(rdSlot), .rdValid_q(rdValid_q), .rdBit_q(rdBit_q), .searchReq(searchReq),
  .searchJoin_q(searchJoin_q), .alarmFlag_q(alarmFlag_q), .convStart_q(convStart_q),
  .convDone(convDone), .parasitePin(parasitePin), .romCode_q(romCode_q)
);

// File: tsa_thermo_pad_tb_top.sv
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tsa_thermo_pad_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, srst = 1'b1, convDone = 1'b0, parasitePin = 1'b0;
  logic busReset, cmdValid, wrValid, rdSlot, rdValid_q, rdBit_q, searchReq, searchJoin_q;
  logic alarmFlag_q, convStart_q, j;
  logic [7:0]  cmdByte, wrByte;
  logic [63:0] romCode_q;
  logic [71:0] v;
  tsa_pkg::tsa_conv_t convResult = '0;
  int err_total = 0, total_checks = 0;

  always #12.5 mclk = ~mclk;

  tsa_thermo_pad #(.COPY_CYCLES(20)) u_tsa_thermo_pad (
    .mclk(mclk), .srst(srst), .busReset(busReset), .cmdValid(cmdValid), .cmdByte(cmdByte),
    .wrValid(wrValid), .wrByte(wrByte), .rdSlot(rdSlot), .rdValid_q(rdValid_q),
    .rdBit_q(rdBit_q), .searchReq(searchReq), .searchJoin_q(searchJoin_q),
    .alarmFlag_q(alarmFlag_q), .convStart_q(convStart_q), .convDone(convDone),
    .convResult(convResult), .parasitePin(parasitePin), .romCode_q(romCode_q));

  tsa_bus_master u_tsa_bus_master (
    .mclk(mclk), .busReset(busReset), .cmdValid(cmdValid), .cmdByte(cmdByte),
    .wrValid(wrValid), .wrByte(wrByte), .rdSlot(rdSlot), .rdValid_q(rdValid_q),
    .rdBit_q(rdBit_q), .searchReq(searchReq), .searchJoin_q(searchJoin_q));

  function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction : crc8

  task automatic start(input logic [7:0] c);
    u_tsa_bus_master.bus_init();
    u_tsa_bus_master.cmd(c);
  endtask : start

  task automatic set_limits(input logic [7:0] up, input logic [7:0] lo);
    start(8'h4E);
    u_tsa_bus_master.wr(up);
    u_tsa_bus_master.wr(lo);
  endtask : set_limits

  task automatic conv(input logic [15:0] t);
    repeat (3) @(posedge mclk);
    convResult <= {t, 8'h05};
    convDone   <= 1'b1;
    @(posedge mclk);
    convDone <= 1'b0;
    @(posedge mclk);
  endtask : conv

  task automatic check_pad(input logic [63:0] e);
    start(8'hBE);
    u_tsa_bus_master.rd(72, v);
    `CHK("padData", e, v[63:0])
    `CHK("padCrc", crc8(e, 64), v[71:64])
  endtask : check_pad

  task automatic t_reset_pad();
    check_pad({8'h10, 8'h0C, 8'hFF, 8'hFF, 8'h46, 8'h4B, 16'h00AA});
    `CHK("romFamily", 8'h5A, romCode_q[7:0])
    `CHK("romCrc", crc8({8'h00, romCode_q[55:0]}, 56), romCode_q[63:56])
  endtask : t_reset_pad

  task automatic t_write_pad();
    set_limits(8'hA5, 8'h3C);
    u_tsa_bus_master.wr(8'h77);
    u_tsa_bus_master.bus_init();
    u_tsa_bus_master.rd(1, v);
    `CHK("idleBit", 1'b1, v[0])
    check_pad({8'h10, 8'h0C, 8'hFF, 8'hFF, 8'h3C, 8'hA5, 16'h00AA});
  endtask : t_write_pad

  task automatic t_alarm();
    logic [7:0]  up[6] = '{8'h19, 8'h19, 8'h19, 8'h19, 8'h00, 8'h00};
    logic [7:0]  lo[6] = '{8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'hF6, 8'hF6};
    logic [15:0] tp[6] = '{16'h0032, 16'h0034, 16'h0033, 16'h0014, 16'hFFCE, 16'hFFFF};
    logic        ex[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      set_limits(up[i], lo[i]);
      start(8'h44);
      conv(tp[i]);
      `CHK("alarmFlag", ex[i], alarmFlag_q)
      u_tsa_bus_master.search(j);
      `CHK("searchJoin", ex[i], j)
    end
  endtask : t_alarm

  task automatic t_power();
    parasitePin <= 1'b1;
    start(8'hB4);
    u_tsa_bus_master.rd(1, v);
    `CHK("parasiteBit", 1'b0, v[0])
    parasitePin <= 1'b0;
    start(8'hB4);
    u_tsa_bus_master.rd(1, v);
    `CHK("externalBit", 1'b1, v[0])
    start(8'h44);
    u_tsa_bus_master.rd(1, v);
    `CHK("convBusy", 1'b0, v[0])
    conv(16'h0032);
    u_tsa_bus_master.rd(1, v);
    `CHK("convDone", 1'b1, v[0])
  endtask : t_power

  task automatic t_copy_reload();
    set_limits(8'h55, 8'hE2);
    start(8'h48);
    u_tsa_bus_master.quiet(40);
    set_limits(8'h01, 8'h02);
    start(8'hB8);
    u_tsa_bus_master.rd(1, v);
    `CHK("reloadBusy", 1'b0, v[0])
    u_tsa_bus_master.quiet(20);
    u_tsa_bus_master.rd(1, v);
    `CHK("reloadDone", 1'b1, v[0])
    check_pad({8'h10, 8'h05, 8'hFF, 8'hFF, 8'hE2, 8'h55, 16'h0032});
  endtask : t_copy_reload

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    repeat (14) @(posedge mclk);
    t_reset_pad();
    t_write_pad();
    t_alarm();
    t_power();
    t_copy_reload();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
endmodule : tsa_thermo_pad_tb_top
